// ### hbsf_pkg.sv
// Constants shared by the half-bridge status and fault logic.
// Assumes a 100 MHz system clock and a 16-bit serial control/status word.
package hbsf_pkg;

  localparam int CLK_MHZ = 100;
  localparam int WORD_W  = 16;
  localparam int NUM_SW  = 12;
  localparam int NUM_CH  = 6;
  localparam int CNT_W   = 5;

  // Control word fields
  localparam int CTL_SRR_BIT = 0;
  localparam int CTL_SW_LSB  = 1;
  localparam int CTL_OLD_BIT = 13;
  localparam int CTL_SCT_BIT = 14;
  localparam int CTL_SE_BIT  = 15;
  localparam logic [WORD_W-1:0] CTL_RESET = 16'hE000;

  // Status word fields
  localparam int ST_TP_BIT  = 0;
  localparam int ST_SW_LSB  = 1;
  localparam int ST_SCD_BIT = 13;
  localparam int ST_EN_BIT  = 14;
  localparam int ST_PSF_BIT = 15;
  localparam logic [WORD_W-1:0] ST_SHUTDOWN = 16'hFFFF;

  // Frame length in clock edges
  localparam logic [CNT_W-1:0] WORD_CNT = 5'h10;

  // Delays in microseconds and their cycle counts
  localparam int SC_LONG_US   = 12000;
  localparam int SC_SHORT_US  = 1500;
  localparam int UV_DELAY_US  = 10;
  localparam int SC_LONG_CYC  = SC_LONG_US * CLK_MHZ;
  localparam int SC_SHORT_CYC = SC_SHORT_US * CLK_MHZ;
  localparam int UV_DELAY_CYC = UV_DELAY_US * CLK_MHZ;

  // Positions in the synchronised pin vector
  localparam int PIN_CS     = 0;
  localparam int PIN_SCLK   = 1;
  localparam int PIN_EN     = 2;
  localparam int PIN_TW     = 3;
  localparam int PIN_TS     = 4;
  localparam int PIN_UV     = 5;
  localparam int PIN_OC_LSB = 6;
  localparam int PIN_OL_LSB = 18;
  localparam int PIN_W      = 30;
  localparam logic [PIN_W-1:0] PIN_IDLE = 30'h00000001;

endpackage

// ### hbsf_core.sv
// Status, enable and protection logic of a six-half-bridge driver.
// Assumes the serial clock idles low and stops while chip select is high;
// analog monitors arrive as asynchronous digital levels.
`timescale 1ns/1ps

// Notes on behaviour
// - Status bit 0 follows the thermal pre-warning level.
// - Status bits 1..12 show switch on/off, low side then high side.
// - With open-load check on, switch bits show open load high.
// - Status bit 13 high once any output tripped by short circuit.
// - Status bit 14 high only when soft enable and enable pin high, or in shutdown.
// - Status bit 15 flags motor supply under-voltage.
// - Thermal shutdown turns all switches off, status reads all ones.
// - Control word resets to E000: enabled, long delay, no check.
// - Disabled device turns outputs off, serial link keeps working.
// - Open-load check low enables pull-down on every low side.
// - Switch status bit follows open-load presence, set and clear.
// - Over-current lasting the programmed delay trips that output.
// - Status-clear bit clears short flag and re-enables outputs.
// - Chip select fall puts pre-warning bit on serial output.
// - Short frame is abandoned; control and status stay unchanged.
// - Shutdown ends only when cool and status-clear written.
// - Lasting under-voltage sets supply flag and disables outputs.
// - Outputs recover with supply; supply flag held until cleared.
// - Fault pin low on current limit, trip or thermal shutdown.
// - Control bit 14 selects long or short short-circuit delay.
// - Control bit 0 clears supply, short and shutdown flags.
// - Control bits 1..12 switch on their outputs.
// - New control word applies at chip select rise, LSB first.
module hbsf_core
  import hbsf_pkg::*;
#(
  parameter int SC_LONG_CYC_P  = SC_LONG_CYC,
  parameter int SC_SHORT_CYC_P = SC_SHORT_CYC,
  parameter int UV_CYC_P       = UV_DELAY_CYC
) (
  // System clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  // Serial link
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_serial_in,
  // Serial data out
  output logic                   o_sdo,
  output logic                   o_sdo_oe_n,
  // Enable pin
  input  wire logic              i_en_pin,
  // Analog monitors
  input  wire logic              i_temp_warn,
  input  wire logic              i_temp_shut,
  input  wire logic              i_motor_supply_uv,
  input  wire logic [NUM_SW-1:0] i_over_current,
  input  wire logic [NUM_SW-1:0] i_open_load,
  // Output stage drive
  output logic [NUM_SW-1:0]      o_switch_on,
  // Low-side pull-downs
  output logic [NUM_CH-1:0]      o_pulldown_en,
  // Open-drain fault pin
  input  wire logic              i_fault_in,
  // Fault pin drive
  output logic                   o_fault_out,
  output logic                   o_fault_oe_n
);

  localparam int SC_W = $clog2(SC_LONG_CYC_P + 1);
  localparam int UV_W = $clog2(UV_CYC_P + 1);

  // Refuse parameters and field maps the logic cannot serve
  generate
    if (SC_SHORT_CYC_P < 1 || SC_LONG_CYC_P < SC_SHORT_CYC_P ||
        UV_CYC_P < 1) begin : g_bad_param
      $error("hbsf_core: delay counts must be >= 1, long >= short");
    end

    if (WORD_W != CTL_SE_BIT + 1 ||
        WORD_W != ST_PSF_BIT + 1) begin : g_bad_word
      $error("hbsf_core: top flag bits must close the word");
    end

    if (NUM_SW != 2 * NUM_CH) begin : g_bad_chan
      $error("hbsf_core: each channel has one low and one high side");
    end

    if (CTL_SW_LSB + NUM_SW != CTL_OLD_BIT ||
        ST_SW_LSB + NUM_SW != ST_SCD_BIT) begin : g_bad_sw_field
      $error("hbsf_core: switch fields must end below the flags");
    end

    if (CTL_SW_LSB != CTL_SRR_BIT + 1 ||
        ST_SW_LSB != ST_TP_BIT + 1) begin : g_bad_low_field
      $error("hbsf_core: switch fields must start above bit zero");
    end

    if (PIN_OC_LSB + NUM_SW != PIN_OL_LSB ||
        PIN_OL_LSB + NUM_SW != PIN_W) begin : g_bad_pins
      $error("hbsf_core: pin vector layout does not match its width");
    end

    if (PIN_OC_LSB != PIN_UV + 1) begin : g_bad_pin_gap
      $error("hbsf_core: monitor levels must follow the supply pin");
    end

    if ((2 ** CNT_W) <= WORD_W ||
        int'(WORD_CNT) != WORD_W) begin : g_bad_cnt
      $error("hbsf_core: frame counter must hold the word length");
    end

    if (SC_W > 31 || UV_W > 31) begin : g_bad_width
      $error("hbsf_core: delay counters wider than supported");
    end
  endgenerate

  // Sticky flag: a set in the same cycle as a clear wins
  function automatic logic sticky(
    input logic held,
    input logic clear_i,
    input logic set_i
  );
    return (held & ~clear_i) | set_i;
  endfunction

  // Per-switch form of the sticky rule
  function automatic logic [NUM_SW-1:0] sticky_vec(
    input logic [NUM_SW-1:0] held,
    input logic              clear_i,
    input logic [NUM_SW-1:0] set_i
  );
    return (held & ~{NUM_SW{clear_i}}) | set_i;
  endfunction

  // All falling clock edges of a frame have been counted
  function automatic logic frame_full(input logic [CNT_W-1:0] cnt);
    return cnt == WORD_CNT;
  endfunction

  // Fault pin request: over-current, tripped switch or shutdown
  function automatic logic fault_req(
    input logic [NUM_SW-1:0] oc_i,
    input logic [NUM_SW-1:0] off_i,
    input logic              shut_i
  );
    return (|oc_i) | (|off_i) | shut_i;
  endfunction

  typedef struct packed {
    // Pin synchronisers and edge history
    logic [PIN_W-1:0]             pin_s1;
    logic [PIN_W-1:0]             pin_s2;
    logic                         cs_d;
    logic                         sclk_d;
    // Frame tracking and shift-out
    logic [CNT_W-1:0]             bit_cnt;
    logic [WORD_W-1:0]            ctrl;
    logic [WORD_W-1:0]            tx;
    logic                         oe_n;
    // Short-circuit protection
    logic [NUM_SW-1:0][SC_W-1:0]  sc_cnt;
    logic [NUM_SW-1:0]            sc_off;
    logic                         sc_flag;
    // Shutdown and supply monitor
    logic                         shut;
    logic [UV_W-1:0]              uv_cnt;
    logic                         uv_off;
    logic                         supply_fail_flag;
    // Output stage and fault pin
    logic [NUM_SW-1:0]            drv;
    logic [NUM_CH-1:0]            pd;
    logic                         fault_oe_n;
    logic                         fault_lvl;
  } hbsf_sys_s;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
  } hbsf_link_s;

  hbsf_sys_s  sys_reg;
  hbsf_sys_s  sys_next;
  hbsf_link_s link_reg;
  hbsf_link_s link_next;

  // Synchronised pin levels
  logic              cs_n_s;
  logic              sclk_s;
  logic              en_pin_s;
  logic              tw_s;
  logic              ts_s;
  logic              uv_s;
  logic [NUM_SW-1:0] oc_s;
  logic [NUM_SW-1:0] ol_s;
  // Frame events
  logic              cs_fall;
  logic              cs_rise;
  logic              sclk_fall;
  logic              sclk_rise;
  logic              load;
  logic              clr;
  // Protection and status
  logic              enabled;
  logic              permit;
  logic              uv_trip;
  logic [NUM_SW-1:0] sc_trip;
  logic [SC_W-1:0]   sc_lim;
  logic [WORD_W-1:0] status;

  // Link domain: serial data shifted in on falling clock edges.
  // Read by the system side only at the synced chip select rise,
  // long after the last falling edge, so the word is stable there.
  // LSB first shift
  always_comb begin
    link_next.shift = {i_serial_in, link_reg.shift[WORD_W-1:1]};
  end

  always_ff @(negedge i_sclk) begin
    link_reg <= link_next;
  end

  // Synchronised pin levels, read only from the second stage
  assign cs_n_s   = sys_reg.pin_s2[PIN_CS];
  assign sclk_s   = sys_reg.pin_s2[PIN_SCLK];
  assign en_pin_s = sys_reg.pin_s2[PIN_EN];
  assign tw_s     = sys_reg.pin_s2[PIN_TW];
  assign ts_s     = sys_reg.pin_s2[PIN_TS];
  assign uv_s     = sys_reg.pin_s2[PIN_UV];
  assign oc_s     = sys_reg.pin_s2[PIN_OC_LSB +: NUM_SW];
  assign ol_s     = sys_reg.pin_s2[PIN_OL_LSB +: NUM_SW];

  assign cs_fall   = sys_reg.cs_d & ~cs_n_s;
  assign cs_rise   = ~sys_reg.cs_d & cs_n_s;
  assign sclk_fall = sys_reg.sclk_d & ~sclk_s & ~cs_n_s;
  assign sclk_rise = ~sys_reg.sclk_d & sclk_s & ~cs_n_s;

  assign load = cs_rise & frame_full(sys_reg.bit_cnt);
  assign clr  = load & link_reg.shift[CTL_SRR_BIT];

  assign enabled = sys_reg.ctrl[CTL_SE_BIT] & en_pin_s;

  // Stages allowed only when enabled, no lockout
  assign permit = enabled & ~sys_reg.shut & ~sys_reg.uv_off;

  assign sc_lim = sys_reg.ctrl[CTL_SCT_BIT] ? SC_W'(SC_LONG_CYC_P - 1)
                                            : SC_W'(SC_SHORT_CYC_P - 1);
  assign uv_trip = uv_s & (sys_reg.uv_cnt == UV_W'(UV_CYC_P - 1));

  always_comb begin
    for (int i = 0; i < NUM_SW; i++) begin
      sc_trip[i] = oc_s[i] & sys_reg.drv[i] & (sys_reg.sc_cnt[i] == sc_lim);
    end
  end

  // Status word as seen by the host
  always_comb begin
    status = '0;
    status[ST_TP_BIT] = tw_s;
    // With check on, every switch bit reads load presence
    if (!sys_reg.ctrl[CTL_OLD_BIT]) begin
      status[ST_SW_LSB +: NUM_SW] = ol_s;
    end else begin
      status[ST_SW_LSB +: NUM_SW] = sys_reg.drv;
    end
    status[ST_SCD_BIT] = sys_reg.sc_flag;
    status[ST_EN_BIT]  = enabled;
    status[ST_PSF_BIT] = sys_reg.supply_fail_flag;
    if (sys_reg.shut) begin
      status = ST_SHUTDOWN;
    end
  end

  always_comb begin
    sys_next = sys_reg;
    sys_next.pin_s1 = {i_open_load, i_over_current, i_motor_supply_uv,
                       i_temp_shut, i_temp_warn, i_en_pin, i_sclk, i_cs_n};
    sys_next.pin_s2 = sys_reg.pin_s1;
    sys_next.cs_d   = cs_n_s;
    sys_next.sclk_d = sclk_s;

    // Frame edge counting
    if (cs_fall) begin
      sys_next.bit_cnt = '0;
    end else if (sclk_fall && !frame_full(sys_reg.bit_cnt)) begin
      sys_next.bit_cnt = sys_reg.bit_cnt + CNT_W'(1);
    end

    if (load) begin
      sys_next.ctrl = link_reg.shift;
    end

    if (cs_fall) begin
      sys_next.tx   = status;
      sys_next.oe_n = 1'b0;
    end else if (cs_rise) begin
      sys_next.oe_n = 1'b1;
    end else if (sclk_rise && sys_reg.bit_cnt != '0) begin
      sys_next.tx = {1'b0, sys_reg.tx[WORD_W-1:1]};
    end

    for (int i = 0; i < NUM_SW; i++) begin
      if (!(oc_s[i] && sys_reg.drv[i])) begin
        sys_next.sc_cnt[i] = '0;
      end else if (sys_reg.sc_cnt[i] != sc_lim) begin
        sys_next.sc_cnt[i] = sys_reg.sc_cnt[i] + SC_W'(1);
      end
    end
    sys_next.sc_off  = sticky_vec(sys_reg.sc_off, clr, sc_trip);
    sys_next.sc_flag = sticky(sys_reg.sc_flag, clr, |sc_trip);

    // Leave shutdown when cool and cleared
    sys_next.shut = sticky(sys_reg.shut, clr & ~ts_s, ts_s);

    if (!uv_s) begin
      sys_next.uv_cnt = '0;
    end else if (!uv_trip) begin
      sys_next.uv_cnt = sys_reg.uv_cnt + UV_W'(1);
    end
    sys_next.uv_off = uv_s & (sys_reg.uv_off | uv_trip);
    sys_next.supply_fail_flag    = sticky(sys_reg.supply_fail_flag, clr, uv_trip);

    sys_next.drv = sys_reg.ctrl[CTL_SW_LSB +: NUM_SW] & ~sys_reg.sc_off &
                   {NUM_SW{permit}};

    sys_next.pd = {NUM_CH{~sys_reg.ctrl[CTL_OLD_BIT]}};

    sys_next.fault_oe_n = ~fault_req(oc_s, sys_reg.sc_off, sys_reg.shut);
    sys_next.fault_lvl  = 1'b0;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sys_reg            <= '0;
      // Pins start at their idle levels
      sys_reg.pin_s1     <= PIN_IDLE;
      sys_reg.pin_s2     <= PIN_IDLE;
      sys_reg.cs_d       <= 1'b1;
      sys_reg.ctrl       <= CTL_RESET;
      sys_reg.oe_n       <= 1'b1;
      sys_reg.fault_oe_n <= 1'b1;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // Outputs straight from registers
  assign o_sdo         = sys_reg.tx[0];
  assign o_sdo_oe_n    = sys_reg.oe_n;
  assign o_switch_on   = sys_reg.drv;
  assign o_pulldown_en = sys_reg.pd;
  assign o_fault_out   = sys_reg.fault_lvl;
  assign o_fault_oe_n  = sys_reg.fault_oe_n;

endmodule

// ### hbsf_core_assertions.sv
// Port checker for the half-bridge status and fault logic.
// Assumes monitors and pins are held steady for several cycles.
`timescale 1ns/1ps
module hbsf_core_chk
  import hbsf_pkg::*;
#(
  parameter int UV_CYC_P = UV_DELAY_CYC
) (
  input wire logic              i_clk_sys,
  input wire logic              i_srst,
  input wire logic              i_cs_n,
  input wire logic              i_en_pin,
  input wire logic              i_temp_shut,
  input wire logic              i_motor_supply_uv,
  input wire logic [NUM_SW-1:0] i_over_current,
  input wire logic              o_sdo_oe_n,
  input wire logic [NUM_SW-1:0] o_switch_on,
  input wire logic              o_fault_out,
  input wire logic              o_fault_oe_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  int uv_cnt;
  // Length of the present under-voltage spell
  always_ff @(posedge i_clk_sys)
    uv_cnt <= (i_srst || !i_motor_supply_uv) ? 0 : uv_cnt + 1;

  AST_RST_OUT: assert property ($fell(i_srst) |->
    o_switch_on == '0 && o_sdo_oe_n && o_fault_oe_n)
    else $error("outputs active after reset");
  AST_EN_OFF: assert property (!i_en_pin [*5] |-> o_switch_on == '0)
    else $error("switches on while disabled");
  AST_SHUT_OFF: assert property (i_temp_shut [*5] |->
    o_switch_on == '0 && !o_fault_oe_n)
    else $error("switches on in shutdown");
  AST_UV_OFF: assert property (uv_cnt > UV_CYC_P + 5 |->
    o_switch_on == '0)
    else $error("switches on in under-voltage");
  AST_OC_FAULT: assert property ((|i_over_current) [*5] |->
    !o_fault_oe_n)
    else $error("fault pin idle on over-current");
  AST_OE_ON: assert property ($fell(i_cs_n) ##1 !i_cs_n [*5] |->
    !o_sdo_oe_n)
    else $error("serial output not enabled");
  AST_OE_OFF: assert property ($rose(i_cs_n) ##1 i_cs_n [*5] |->
    o_sdo_oe_n)
    else $error("serial output not released");
  AST_FAULT_LVL: assert property (!o_fault_oe_n |-> !o_fault_out)
    else $error("fault pin driven high");

  cover property ($fell(i_cs_n) ##[1:6] !o_sdo_oe_n);
  cover property (i_temp_shut ##5 o_switch_on == '0);
  cover property (uv_cnt > UV_CYC_P + 5);
endmodule

bind hbsf_core hbsf_core_chk #(.UV_CYC_P(UV_CYC_P)) chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cs_n(i_cs_n),
  .i_en_pin(i_en_pin), .i_temp_shut(i_temp_shut),
  .i_motor_supply_uv(i_motor_supply_uv),
  .i_over_current(i_over_current), .o_sdo_oe_n(o_sdo_oe_n),
  .o_switch_on(o_switch_on), .o_fault_out(o_fault_out),
  .o_fault_oe_n(o_fault_oe_n));

// ### hbsf_host.sv
// Host microcontroller model for the serial link.
// Assumes the serial output settles within 45 ns of a link clock rise.
`timescale 1ns/1ps
module hbsf_host (
  // Link pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  event        got;
  logic [15:0] rx;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input int n);
    o_cs_n = 1'b0;
    #150 rx = 16'h0000;
    rx[0] = i_sdo;
    for (int k = 0; k < n; k++) begin
      o_sdi = w[k];
      #15 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
      #30 if (k > 0) rx[k] = i_sdo;
    end
    o_sdi = ~o_sdi;
    #40 o_cs_n = 1'b1;
    if (n == 16) ->got;
    #100;
  endtask
endmodule

// ### half_bridge_status_fault_logic_test.sv
// Bench for the half-bridge status and fault logic.
// Assumes the host model drives the link; short delays set by parameter.
`timescale 1ns/1ps
module half_bridge_status_fault_logic_test;
  import hbsf_pkg::*;
  logic clk = 0, srst = 1, en = 0, tw = 0, ts = 0, uv = 0, tp = 0;
  logic short_circuit_flag = 0, enb = 1, supply_fail_flag = 0, shut = 0;
  logic sdo, oe_n, fo, foe_n, sclk, cs_n, sdi;
  logic [11:0] oc = '0, ol = '0, sw, sw_on;
  logic [5:0]  pd;
  logic [15:0] q[$];
  int err_total = 0, tests_run = 0;
  always #5 clk = ~clk;
  hbsf_core #(.SC_LONG_CYC_P(40), .SC_SHORT_CYC_P(10), .UV_CYC_P(8)) uut (
    .i_clk_sys(clk), .i_srst(srst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_in(sdi), .o_sdo(sdo), .o_sdo_oe_n(oe_n), .i_en_pin(en),
    .i_temp_warn(tw), .i_temp_shut(ts), .i_motor_supply_uv(uv),
    .i_over_current(oc), .i_open_load(ol), .o_switch_on(sw_on),
    .o_pulldown_en(pd), .i_fault_in(foe_n ? 1'b1 : fo),
    .o_fault_out(fo), .o_fault_oe_n(foe_n));
  hbsf_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
    .i_sdo(oe_n ? 1'bz : sdo));
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Frame writing w; notes the status due back
  task automatic fr(logic [15:0] w, logic [11:0] st);
    q.push_back(shut ? 16'hFFFF : {supply_fail_flag, enb, short_circuit_flag, st, tp});
    host.xfer(w, 16);
    cyc(6);
  endtask
  // Control word from switches and {enable, delay, check_n, clear}
  function automatic logic [15:0] cw(logic [11:0] v, logic [3:0] c);
    return {c[3:1], v, c[0]};
  endfunction
  always @(host.got) chk("status", host.rx, q.pop_front());
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    complete_run;
  end
  initial begin
    void'($urandom(86));
    sw = 12'($urandom) | 12'h001;
    cyc(10);
    srst = 0;
    en = 1;
    cyc(4);
    fr(cw(sw, 4'hE), 12'h000);
    chk("switch", sw_on, sw);
    tw = 1;
    cyc(4);
    tp = 1;
    fr(cw(sw, 4'hE), sw);
    host.xfer(16'h0000, 1);
    chk("prewarn", host.rx[0], 1'b1);
    cyc(6);
    chk("hold", sw_on, sw);
    fr(cw(sw, 4'hE), sw);
    tw = 0;
    en = 0;
    cyc(5);
    tp = 0;
    chk("disable", sw_on, 12'h000);
    en = 1;
    cyc(5);
    chk("enable", sw_on, sw);
    fr(cw(12'h000, 4'h6), sw);
    enb = 0;
    fr(cw(12'h000, 4'hC), 12'h000);
    enb = 1;
    chk("pulldown", pd, 6'h3F);
    ol = 12'($urandom);
    cyc(4);
    fr(cw(12'h000, 4'hC), ol);
    // one high side on, idle one shows load
    ol = 12'h008;
    cyc(4);
    fr(cw(12'h002, 4'hC), ol);
    ol = '0;
    cyc(4);
    fr(cw(sw, 4'hE), 12'h000);
    oc = 12'h001;
    cyc(25);
    oc = '0;
    cyc(4);
    chk("long", sw_on, sw);
    fr(cw(sw, 4'hA), sw);
    oc = 12'h001;
    cyc(25);
    oc = '0;
    cyc(4);
    chk("trip", sw_on, sw & 12'hFFE);
    chk("fault trip", foe_n, 1'b0);
    short_circuit_flag = 1;
    fr(cw(sw, 4'hB), sw & 12'hFFE);
    short_circuit_flag = 0;
    chk("rearm", sw_on, sw);
    chk("fault idle", foe_n, 1'b1);
    uv = 1;
    cyc(20);
    chk("uv off", sw_on, 12'h000);
    uv = 0;
    cyc(6);
    chk("uv back", sw_on, sw);
    supply_fail_flag = 1;
    fr(cw(sw, 4'hB), sw);
    supply_fail_flag = 0;
    fr(cw(sw, 4'hA), sw);
    ts = 1;
    cyc(6);
    chk("shut", sw_on, 12'h000);
    chk("fault shut", foe_n, 1'b0);
    shut = 1;
    fr(cw(sw, 4'hA), sw);
    ts = 0;
    cyc(6);
    chk("latched", sw_on, 12'h000);
    fr(cw(sw, 4'hB), sw);
    shut = 0;
    chk("resume", sw_on, sw);
    fr(cw(sw, 4'hA), sw);
    cyc(10);
    complete_run;
  end
endmodule
